// >>> arith_defines.svh
// Offsets, field positions, reset values and counts of the arithmetic unit.
// Assumes a byte-wide register bus on classic Wishbone with word addresses.
`ifndef ARITH_DEFINES_SVH
`define ARITH_DEFINES_SVH

// ****************************************
// Register indices and byte addresses (index times four)
// ****************************************
`define IDX_CALC_INDEX 8'hEE
`define IDX_CALC_WINDOW 8'hEF
`define IDX_CALC_CTRL 8'hF7
`define ADR_CALC_INDEX (10'h3B8)
`define ADR_CALC_WINDOW (10'h3BC)
`define ADR_CALC_CTRL (10'h3DC)

// ****************************************
// Control and status fields and resets
// ****************************************
`define BIT_ZERO_DIV 2
`define BIT_DIV_DONE 1
`define BIT_DIV_START 0
`define RST_CTRL 8'h02
`define RST_INDEX 8'h00

// ****************************************
// Internal byte indices
// ****************************************
`define BYTE_MA 8'h00
`define BYTE_MB 8'h02
`define BYTE_MO 8'h04
`define BYTE_DA 8'h08
`define BYTE_DB 8'h0C
`define BYTE_DQ 8'h0E
`define BYTE_DR 8'h12
`define BYTE_END 8'h14

// ****************************************
// Timing
// ****************************************
`define DIV_CYCLES 6'd32

`endif

// >>> arith_pkg.sv
// Types shared by the arithmetic unit and its helpers.
// Assumes arith_defines.svh is available on the include path.
package arith_pkg;
   typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} divState_e;
   typedef logic [7:0] byte_t;
endpackage

// >>> div_link_if.sv
// Interface joining the top module to its divider core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface div_link_if;
   logic start;
   logic [31:0] dividend;
   logic [15:0] divisor;
   logic busy;
   logic zeroDiv;
   logic [31:0] quotient;
   logic [15:0] remainder;
   modport ctrl (output start, output dividend, output divisor,
      input busy, input zeroDiv, input quotient, input remainder);
   modport core (input start, input dividend, input divisor,
      output busy, output zeroDiv, output quotient, output remainder);
endinterface

// >>> signed_divider.sv
// Signed 32 by 16 restoring divider taking 32 cycles per division.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
`include "arith_defines.svh"
module signed_divider
   import arith_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   div_link_if.core link
);
   typedef struct packed
   {
      divState_e st;
      logic [5:0] cnt;
      logic [31:0] quo;
      logic [16:0] rem;
      logic [15:0] dsr;
      logic negQ;
      logic negR;
      logic zero;
      logic [31:0] qOut;
      logic [15:0] rOut;
   } div_s;
   div_s state_q;
   div_s state_d;
   logic [16:0] trial;

   // Absolute value; the sign is re-applied once the loop ends.
   function automatic logic [31:0] absVal(input logic [31:0] v);
      absVal = v[31] ? 32'(-v) : v;
   endfunction

   // One shift-subtract step per cycle on magnitudes.
   always_comb
   begin
      state_d = state_q;
      trial = 17'({state_q.rem[15:0], state_q.quo[31]}) - {1'b0, state_q.dsr};
      case (state_q.st)
         DIV_IDLE:
         begin
            if (link.start)
            begin
               state_d.zero = (link.divisor == 16'h0000);
               state_d.negQ = link.dividend[31] ^ link.divisor[15];
               state_d.negR = link.dividend[31];
               state_d.quo = absVal(link.dividend);
               state_d.dsr = 16'(absVal({{16{link.divisor[15]}},
                  link.divisor}));
               state_d.rem = 17'h00000;
               state_d.cnt = 6'h00;
               state_d.st = DIV_RUN;
            end
         end
         DIV_RUN:
         begin
            if (!trial[16])
            begin
               state_d.rem = trial;
               state_d.quo = {state_q.quo[30:0], 1'b1};
            end
            else
            begin
               state_d.rem = {state_q.rem[15:0], state_q.quo[31]};
               state_d.quo = {state_q.quo[30:0], 1'b0};
            end
            state_d.cnt = state_q.cnt + 6'h01;
            if (state_q.cnt == `DIV_CYCLES - 6'd1)
            begin
               state_d.st = DIV_IDLE;
               if (state_q.zero)
               begin
                  state_d.qOut = 32'h7FFFFFFF;
                  state_d.rOut = link.dividend[15:0];
               end
               else
               begin
                  state_d.qOut = state_q.negQ ? 32'(-state_d.quo)
                     : state_d.quo;
                  state_d.rOut = state_q.negR ? 16'(-state_d.rem[15:0])
                     : state_d.rem[15:0];
               end
            end
         end
         default: state_d.st = DIV_IDLE;
      endcase
   end

   // Single register for all state.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign link.busy = (state_q.st == DIV_RUN);
   assign link.zeroDiv = state_q.zero;
   assign link.quotient = state_q.qOut;
   assign link.remainder = state_q.rOut;

   property p_div_len;
      @(posedge clk) disable iff (rst)
      $rose(link.busy) |-> link.busy [*8] ##25 !link.busy;
   endproperty
   a_div_len: assert property (p_div_len) else $error("div length");

   property p_zero_q;
      @(posedge clk) disable iff (rst)
      $fell(link.busy) && link.zeroDiv |-> link.quotient == 32'h7FFFFFFF;
   endproperty
   a_zero_q: assert property (p_zero_q) else $error("zero quot");
endmodule

// >>> signed_arith_unit.sv
// Contract
// - Operands and results are signed two's complement.
// - Product ready the cycle after operand write.
// - Division takes thirty-two clock cycles.
// - Zero divisor: flag, maximum quotient, remainder=dividend low 16 bits.
// - Window access increments the index.
// - Window accesses the byte the index selects.
// - Index is 8-bit read/write, resets zero.
// - Control: zero flag, done flag, self-clearing start.
// - Done reads 0 while dividing, else 1.
// - Multiplicands at bytes 0..3, MSB first.
// - Product at bytes 4..7, MSB first.
// - Dividend bytes 8..11, divisor 12..13.
// - Quotient bytes 14..17, remainder 18..19.
//
// Top of the signed arithmetic unit, a Wishbone classic slave.
// Assumes an 8-bit data bus in the low lanes of a word-addressed map.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "arith_defines.svh"
module signed_arith_unit
   import arith_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [9:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed
   {
      logic [7:0] index;
      logic [79:0] opBytes;
      logic [31:0] product;
      logic startBit;
      logic [31:0] rdData;
      logic ack;
   } top_s;
   top_s state_q;
   top_s state_d;
   div_link_if link ();
   logic access;
   logic winWr;
   logic divGo;
   byte_t winByte;
   logic [7:0] ctrlVal;

   // Product from the multiplicand bytes, signed.
   function automatic logic [31:0] mulOf(input logic [31:0] ab);
      // Both factors widen first so the product keeps all 32 bits.
      mulOf = 32'($signed(ab[31:16])) * 32'($signed(ab[15:0]));
   endfunction

   // Read mux over the internal byte space; gaps read zero.
   function automatic byte_t pick(input logic [7:0] i,
      input logic [79:0] ops, input logic [31:0] mo,
      input logic [31:0] q, input logic [15:0] r);
      logic [159:0] all;
      all = {ops[79:48], mo, ops[47:0], q, r};
      if (i < `BYTE_END)
         pick = all[8'(159 - 8 * i) -: 8];
      else
         pick = 8'h00;
   endfunction

   // Control readback: done is 1 unless a division runs.
   assign ctrlVal = {5'h00, link.zeroDiv, !link.busy,
      state_q.startBit};
   assign access = wb_cyc_i && wb_stb_i && !state_q.ack;
   assign winWr = access && wb_we_i && wb_sel_i[0]
      && wb_adr_i == `ADR_CALC_WINDOW;
   assign winByte = wb_dat_i[7:0];

   // Bus handling, byte storage and start generation.
   always_comb
   begin
      state_d = state_q;
      state_d.ack = access;
      state_d.startBit = 1'b0;
      divGo = 1'b0;
      if (access && wb_adr_i == `ADR_CALC_INDEX)
      begin
         if (wb_we_i && wb_sel_i[0])
            state_d.index = winByte;
         state_d.rdData = {24'h000000, state_q.index};
      end
      else if (access && wb_adr_i == `ADR_CALC_WINDOW)
      begin
         state_d.rdData = {24'h000000, pick(state_q.index,
            state_q.opBytes, state_q.product, link.quotient,
            link.remainder)};
         state_d.index = state_q.index + 8'h01;
         if (winWr)
         begin
            if (state_q.index < `BYTE_MO)
               state_d.opBytes[8'(79 - 8 * state_q.index) -: 8] = winByte;
            else if (state_q.index >= `BYTE_DA && state_q.index < `BYTE_DQ)
               state_d.opBytes[8'(111 - 8 * state_q.index) -: 8] = winByte;
            if (state_q.index == `BYTE_DB + 8'h01)
               divGo = 1'b1;
         end
      end
      else if (access && wb_adr_i == `ADR_CALC_CTRL)
      begin
         state_d.rdData = {24'h000000, ctrlVal};
         if (wb_we_i && wb_sel_i[0] && winByte[`BIT_DIV_START])
         begin
            state_d.startBit = 1'b1;
            divGo = 1'b1;
         end
      end
      else if (access)
         state_d.rdData = 32'h00000000;
      state_d.product = mulOf(state_d.opBytes[79:48]);
   end

   // Registered state; start to divider is the request registered in goQ, one cycle later and only while not busy.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= '0;
         state_q.index <= `RST_INDEX;
      end
      else
         state_q <= state_d;
   end

   logic goQ;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         goQ <= 1'b0;
      else
         goQ <= divGo && !link.busy;
   end

   // Operands latched by the divider at the start pulse.
   assign link.start = goQ;
   assign link.dividend = state_q.opBytes[47:16];
   assign link.divisor = state_q.opBytes[15:0];

   signed_divider divCore
   (
      .clk(clk),
      .rst(rst),
      .link(link)
   );

   assign wb_dat_o = state_q.rdData;
   assign wb_ack_o = state_q.ack;

   property p_ack_one;
      @(posedge clk) disable iff (rst)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack twice");

   property p_idx_inc;
      @(posedge clk) disable iff (rst)
      access && wb_adr_i == `ADR_CALC_WINDOW |=>
         state_q.index == 8'($past(state_q.index) + 8'h01);
   endproperty
   a_idx_inc: assert property (p_idx_inc) else $error("index inc");

   property p_start_clr;
      @(posedge clk) disable iff (rst)
      state_q.startBit |=> !state_q.startBit;
   endproperty
   a_start_clr: assert property (p_start_clr) else $error("start");

   property p_busy_after;
      @(posedge clk) disable iff (rst)
      goQ |=> link.busy;
   endproperty
   a_busy_after: assert property (p_busy_after) else $error("no run");

   property p_prod;
      @(posedge clk) disable iff (rst)
      1'b1 |-> state_q.product == mulOf(state_q.opBytes[79:48]);
   endproperty
   a_prod: assert property (p_prod) else $error("product");

   property p_rst_ctrl;
      @(posedge clk) disable iff (rst)
      $fell(rst) |-> ctrlVal == `RST_CTRL;
   endproperty
   a_rst_ctrl: assert property (p_rst_ctrl) else $error("reset");

   property p_unmapped;
      @(posedge clk) disable iff (rst)
      access && !wb_we_i && wb_adr_i == `ADR_CALC_WINDOW
         && state_q.index >= `BYTE_END |=> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("gap");

   property p_wrap;
      @(posedge clk) disable iff (rst)
      access && wb_adr_i == `ADR_CALC_WINDOW && state_q.index == 8'hFF
         |=> state_q.index == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap");
endmodule

// >>> signed_arith_unit_tb.sv
// Self-checking bench for the signed arithmetic unit over Wishbone.
// Assumes arith_pkg and arith_defines.svh are compiled and included first.
`timescale 1ns/1ps
`include "arith_defines.svh"
module signed_arith_unit_tb;
   import arith_pkg::*;
   typedef struct {logic [15:0] a; logic [15:0] b; logic [31:0] p;} mulRow_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] adr = 10'h000;
   logic [31:0] datI = 32'h00000000;
   logic [3:0] sel = 4'h1;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [31:0] datO;
   logic ack;
   int badCount = 0;
   int totalChecks = 0;
   int cycles = 0;
   mulRow_s rows [4] = '{'{16'h0003, 16'h0004, 32'h0000000C},
      '{16'hFFFE, 16'h0005, 32'hFFFFFFF6},
      '{16'h8000, 16'h8000, 32'h40000000},
      '{16'h7FFF, 16'hFFFF, 32'hFFFF8001}};

   signed_arith_unit u_signed_arith_unit (.clk(clk), .rst(rst),
      .wb_adr_i(adr), .wb_dat_i(datI), .wb_sel_i(sel), .wb_we_i(we),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(datO), .wb_ack_o(ack));

   // ****************************************
   // Clock, watchdog and verdict
   // ****************************************
   // Free-running clock of 4 ns.
   always #2 clk = ~clk;

   // Each access gives up after 16 cycles without ack; a 6000-cycle ceiling still ends a hung run.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         badCount++;
         completeRun();
      end
   end

   task automatic completeRun;
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ****************************************
   // Bus tasks
   // ****************************************
   // One classic cycle; request held until ack is seen at a rising edge, or 16 more edges pass.
   task automatic access(input logic [9:0] a, input logic w, input byte_t d,
      output byte_t q);
      int n;
      @(posedge clk);
      adr <= a;
      we <= w;
      datI <= {24'h000000, d};
      cyc <= 1'b1;
      stb <= 1'b1;
      n = 0;
      @(posedge clk);
      while (ack !== 1'b1 && n < 16)
      begin
         @(posedge clk);
         n++;
      end
      q = datO[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] a, input byte_t d);
      byte_t q;
      access(a, 1'b1, d, q);
   endtask

   task automatic checkRd(input logic [9:0] a, input byte_t e, input string s);
      byte_t q;
      access(a, 1'b0, 8'h00, q);
      totalChecks++;
      if (q !== e)
      begin
         badCount++;
         $display("wrong value %s expected %h seen %h", s, e, q);
      end
   endtask

   // Polls the done flag the way software must before reading results.
   task automatic waitDone;
      byte_t q;
      int n;
      q = 8'h00;
      n = 0;
      while (q[1] !== 1'b1 && n < 40)
      begin
         access(`ADR_CALC_CTRL, 1'b0, 8'h00, q);
         n++;
      end
   endtask

   // Loads operands, which starts the division, then reads all results.
   task automatic divide(input logic [31:0] a, input logic [15:0] b,
      input logic [31:0] eq, input logic [15:0] er);
      byte_t z;
      z = (b == 16'h0000) ? 8'h04 : 8'h00;
      wr(`ADR_CALC_INDEX, `BYTE_DA);
      for (int i = 3; i >= 0; i--)
         wr(`ADR_CALC_WINDOW, a[8*i +: 8]);
      wr(`ADR_CALC_WINDOW, b[15:8]);
      wr(`ADR_CALC_WINDOW, b[7:0]);
      checkRd(`ADR_CALC_CTRL, z, "status busy");
      waitDone();
      checkRd(`ADR_CALC_CTRL, z | 8'h02, "status done");
      for (int i = 3; i >= 0; i--)
         checkRd(`ADR_CALC_WINDOW, eq[8*i +: 8], "quotient");
      for (int i = 1; i >= 0; i--)
         checkRd(`ADR_CALC_WINDOW, er[8*i +: 8], "remainder");
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   // Reset checks first, then the table of products, divisions and the awkward cases.
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      checkRd(`ADR_CALC_CTRL, `RST_CTRL, "status reset");
      checkRd(`ADR_CALC_INDEX, `RST_INDEX, "index reset");
      checkRd(`ADR_CALC_WINDOW, 8'h00, "window reset");
      checkRd(`ADR_CALC_INDEX, 8'h01, "index step");
      $display("test reset done");
      foreach (rows[r])
      begin
         wr(`ADR_CALC_INDEX, `BYTE_MA);
         wr(`ADR_CALC_WINDOW, rows[r].a[15:8]);
         wr(`ADR_CALC_WINDOW, rows[r].a[7:0]);
         wr(`ADR_CALC_WINDOW, rows[r].b[15:8]);
         wr(`ADR_CALC_WINDOW, rows[r].b[7:0]);
         for (int i = 3; i >= 0; i--)
            checkRd(`ADR_CALC_WINDOW, rows[r].p[8*i +: 8], "product");
         checkRd(`ADR_CALC_INDEX, `BYTE_DA, "index after");
      end
      $display("test multiply done");
      divide(32'hFFFFFF9C, 16'h0007, 32'hFFFFFFF2, 16'hFFFE);
      wr(`ADR_CALC_CTRL, 8'h06);
      checkRd(`ADR_CALC_CTRL, 8'h02, "status read only");
      divide(32'h00001234, 16'h0000, 32'h7FFFFFFF, 16'h1234);
      wr(`ADR_CALC_CTRL, 8'h01);
      checkRd(`ADR_CALC_CTRL, 8'h04, "start cleared");
      waitDone();
      checkRd(`ADR_CALC_CTRL, 8'h06, "restart done");
      $display("test divide done");
      wr(`ADR_CALC_INDEX, 8'hFF);
      wr(`ADR_CALC_WINDOW, 8'hAA);
      checkRd(`ADR_CALC_INDEX, 8'h00, "index wrap");
      wr(`ADR_CALC_INDEX, 8'h30);
      checkRd(`ADR_CALC_WINDOW, 8'h00, "unmapped byte");
      checkRd(10'h000, 8'h00, "unmapped address");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      checkRd(`ADR_CALC_INDEX, `RST_INDEX, "index second reset");
      $display("test index done");
      completeRun();
   end
endmodule
